// *** rtl/interrupt_vector_table_select.sv ***
/*
  Vector address generator: picks the default or alternate table and
  turns a trap, or the highest natural-priority interrupt request, into
  the program-memory address of its vector. The handler address read
  from that location is loaded by this block as the new program counter.
  Assumes the core holds the request inputs steady until accepted, and
  that control and configuration words arrive as plain input levels.
*/
`timescale 1ns/1ps

// Summary of operation
// - Enabled alternate table redirects trap and interrupt vectors; reset still starts at zero
// - Alternate needs boot segment, permit, enable
// - Alternate base is (limit minus one) times 0x800
// - Both tables share identical offset layout
// - Reset clears state, program counter starts zero
// - Reset jump and target occupy lowest words
// - Eight trap slots from 0x04 to 0x12
// - Interrupts 0..117 follow; lower address higher priority
// - Vector holds 24-bit handler start address
module interrupt_vector_table_select #(
  parameter int unsigned NUM_IRQ = 118,
  parameter logic [117:0] IRQ_IMPLEMENTED = {118{1'b1}}
) (
  input  wire logic                 clk_in,
  input  wire logic                 reset_n_in,
  input  wire logic [15:0]          interrupt_control_two_in,
  input  wire logic [15:0]          security_config_word_in,
  input  wire logic                 boot_segment_defined_in,
  input  wire logic [12:0]          boot_segment_limit_in,
  input  wire logic                 trap_req_in,
  input  wire logic [2:0]           trap_num_in,
  input  wire logic [NUM_IRQ-1:0]   irq_pending_in,
  input  wire logic                 fetch_ready_in,
  input  wire logic [23:0]          handler_addr_in,
  input  wire logic                 handler_valid_in,
  output logic                      fetch_valid_out,
  output logic [23:0]               fetch_addr_out,
  output logic [6:0]                fetch_irq_out,
  output logic                      fetch_is_trap_out,
  output logic                      alt_table_active_out,
  output logic [23:0]               alt_table_base_out,
  output logic                      pc_load_out,
  output logic [23:0]               program_counter_out
);

  // Refuse a build whose request count does not match the fixed
  // table layout; the vector offsets below assume 118 slots
  initial begin
    if (NUM_IRQ != 118) begin
      $error("interrupt_vector_table_select: table layout holds 118 interrupts");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table selection

  logic        alt_table_enable;        // Runtime enable from control word
  logic        alt_table_config_permit; // Permit from configuration word
  logic [23:0] table_base;              // Base of selected table

  assign alt_table_enable        =
    interrupt_control_two_in[vector_select_pkg::ALT_ENABLE_BIT];
  assign alt_table_config_permit =
    security_config_word_in[vector_select_pkg::CFG_PERMIT_BIT];

  // A zero limit would wrap the base below zero, so treat it as undefined
  logic segment_ok;
  assign segment_ok = boot_segment_defined_in && (boot_segment_limit_in != 13'h0000);

  // Base is the start of the last boot segment page
  logic [23:0] alt_base;
  assign alt_base = 24'(({11'h000, boot_segment_limit_in} - 24'h000001)
                    * vector_select_pkg::PAGE_SIZE);

  // All three gates must be open; any one closed falls back to the
  // default table at address zero
  logic alt_use;
  assign alt_use = segment_ok && alt_table_config_permit && alt_table_enable;
  assign table_base = alt_use ? alt_base : 24'h000000;

  ////////////////////////////////////////////////////////////////////////////
  // Request arbitration

  logic [NUM_IRQ-1:0] irq_live;    // Requests on implemented slots only
  logic               irq_any;     // Some implemented request pending
  logic [6:0]         irq_win;     // Highest natural priority request

  // The picker is a plain priority chain; a tree would be faster,
  // but the chain keeps the lowest-index-wins order easy to follow
  // Reserved request numbers never reach the picker
  assign irq_live = irq_pending_in & IRQ_IMPLEMENTED[NUM_IRQ-1:0];

  irq_priority_pick #(
    .NUM   (NUM_IRQ),
    .IDX_W (7)
  ) u_pick (
    .pending_in (irq_live),
    .any_out    (irq_any),
    .index_out  (irq_win)
  );

  // Reserved trap slots produce no fetch
  logic trap_live;
  assign trap_live = trap_req_in
                  && (trap_num_in != vector_select_pkg::TRAP_RSVD_A)
                  && (trap_num_in != vector_select_pkg::TRAP_RSVD_B);

  // Slots are two words apart, for traps and interrupts alike
  // Offsets within a table, identical for both tables
  logic [23:0] trap_offset;
  logic [23:0] irq_offset;
  assign trap_offset = vector_select_pkg::TRAP_BASE_OFFSET
                     + {20'h00000, trap_num_in, 1'b0};
  assign irq_offset  = vector_select_pkg::IRQ_BASE_OFFSET
                     + {16'h0000, irq_win, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Fetch sequencer

  // One fetch is in flight at a time: IDLE takes a request, FETCH
  // offers the vector address until the core accepts it, LOAD waits
  // for the handler address read from that vector location.
  // Requests arriving outside IDLE wait; the core holds them.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_LOAD
  } seq_state_t;

  seq_state_t state;      // Current sequencer step
  seq_state_t next_state; // Step after the coming edge

  // Next step; every branch names a successor so no latch is
  // inferred and a corrupted state falls back to idle
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        // Wait for a live trap or an implemented request
        if (trap_live || irq_any) begin
          next_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // Address stays offered until the core takes it
        if (fetch_ready_in) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        // Handler address arrives from the vector location
        if (handler_valid_in) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        // Unreachable encoding: recover to idle
        next_state = ST_IDLE;
      end
    endcase
  end

  // State register; reset returns to idle with nothing in flight
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Capture the fetch address; traps outrank every interrupt
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fetch_addr_out    <= vector_select_pkg::RESET_JUMP_ADDR;
      fetch_irq_out     <= 7'h00;
      fetch_is_trap_out <= 1'b0;
    end else if (state == ST_IDLE) begin
      if (trap_live) begin
        fetch_addr_out    <= table_base + trap_offset;
        fetch_is_trap_out <= 1'b1;
        fetch_irq_out     <= 7'h00;
      end else if (irq_any) begin
        fetch_addr_out    <= table_base + irq_offset;
        fetch_is_trap_out <= 1'b0;
        fetch_irq_out     <= irq_win;
      end
    end
  end

  // Offered straight from the state, so the core sees it the cycle
  // after the request is taken, with the address already registered
  assign fetch_valid_out = (state == ST_FETCH);

  // The program counter moves only here; reset puts it at zero
  // Handler address becomes the new program counter
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      program_counter_out <= vector_select_pkg::RESET_JUMP_ADDR;
      pc_load_out         <= 1'b0;
    end else begin
      pc_load_out <= (state == ST_LOAD) && handler_valid_in;
      if ((state == ST_LOAD) && handler_valid_in) begin
        program_counter_out <= handler_addr_in;
      end
    end
  end

  // The base is shown even while the alternate table is off, so it
  // can be inspected; it wraps to the top page when the limit is zero
  // Visible table selection status, registered
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      alt_table_active_out <= 1'b0;
      alt_table_base_out   <= 24'h000000;
    end else begin
      alt_table_active_out <= alt_use;
      alt_table_base_out   <= alt_base;
    end
  end

endmodule

// *** rtl/vector_select_pkg.sv ***
/*
  Constants for the vector table select block: table layout, trap
  slots, control and configuration bit positions, widths.
  Assumes a core with a 24-bit program address space.
*/
package vector_select_pkg;

  // Address and field widths
  localparam int unsigned ADDR_W      = 24;
  localparam int unsigned LIMIT_W     = 13;
  localparam int unsigned IRQ_W       = 7;
  localparam int unsigned TRAP_W      = 3;
  localparam int unsigned CTRL_W      = 16;

  // Control and configuration bit positions
  localparam int unsigned ALT_ENABLE_BIT  = 8;
  localparam int unsigned CFG_PERMIT_BIT  = 15;

  // Table layout
  localparam logic [23:0] RESET_JUMP_ADDR   = 24'h000000;
  localparam logic [23:0] RESET_TARGET_ADDR = 24'h000002;
  localparam logic [23:0] TRAP_BASE_OFFSET  = 24'h000004;
  localparam logic [23:0] TRAP_LAST_OFFSET  = 24'h000012;
  localparam logic [23:0] IRQ_BASE_OFFSET   = 24'h000014;
  localparam logic [23:0] IRQ_LAST_OFFSET   = 24'h0000fe;
  localparam logic [23:0] PAGE_SIZE         = 24'h000800;
  localparam logic [6:0]  IRQ_LAST          = 7'h75;

  // Trap numbers in natural priority order
  localparam logic [2:0] TRAP_OSC_FAIL   = 3'h0;
  localparam logic [2:0] TRAP_ADDR_ERR   = 3'h1;
  localparam logic [2:0] TRAP_HARD_ERR   = 3'h2;
  localparam logic [2:0] TRAP_STACK_ERR  = 3'h3;
  localparam logic [2:0] TRAP_MATH_ERR   = 3'h4;
  localparam logic [2:0] TRAP_RSVD_A     = 3'h5;
  localparam logic [2:0] TRAP_SOFT_ERR   = 3'h6;
  localparam logic [2:0] TRAP_RSVD_B     = 3'h7;

  // Fetch request kinds
  typedef enum logic [1:0] {
    KIND_TRAP,
    KIND_IRQ
  } fetch_kind_t;

endpackage

// *** rtl/irq_priority_pick.sv ***
/*
  Fixed natural-priority picker: lowest-numbered active request wins.
  Assumes the pending vector is already masked by enables.
*/
`timescale 1ns/1ps
module irq_priority_pick #(
  parameter int unsigned NUM   = 118,
  parameter int unsigned IDX_W = 7
) (
  input  wire logic [NUM-1:0]   pending_in,
  output logic                  any_out,
  output logic [IDX_W-1:0]      index_out
);

  initial begin
    if (NUM < 1 || NUM > (1 << IDX_W)) begin
      $error("irq_priority_pick: NUM does not fit IDX_W");
    end
  end

  // Scan from the top down so the lowest index is the last to win
  always_comb begin
    any_out   = 1'b0;
    index_out = '0;
    for (int i = NUM - 1; i >= 0; i--) begin
      if (pending_in[i]) begin
        any_out   = 1'b1;
        index_out = IDX_W'(i);
      end
    end
  end

endmodule

// *** dv/vector_select_sva.sv ***
/* Checker for the vector select block.
   Assumes it is bound to interrupt_vector_table_select. */
`timescale 1ns/1ps
module vector_select_sva #(
  parameter int unsigned NUM_IRQ = 118
) (
  input wire logic               clk_in,
  input wire logic               reset_n_in,
  input wire logic [15:0]        interrupt_control_two_in,
  input wire logic [15:0]        security_config_word_in,
  input wire logic               boot_segment_defined_in,
  input wire logic [12:0]        boot_segment_limit_in,
  input wire logic               trap_req_in,
  input wire logic [NUM_IRQ-1:0] irq_pending_in,
  input wire logic               fetch_ready_in,
  input wire logic [23:0]        handler_addr_in,
  input wire logic               handler_valid_in,
  input wire logic               fetch_valid_out,
  input wire logic [23:0]        fetch_addr_out,
  input wire logic [6:0]         fetch_irq_out,
  input wire logic               fetch_is_trap_out,
  input wire logic               alt_table_active_out,
  input wire logic [23:0]        alt_table_base_out,
  input wire logic               pc_load_out,
  input wire logic [23:0]        program_counter_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // Table base in use; zero when the default table applies
  wire [23:0] base = alt_table_active_out ? alt_table_base_out : 24'h000000;
  // All three gates must be open for the alternate table
  wire en = boot_segment_defined_in && boot_segment_limit_in != 13'h0000 &&
            security_config_word_in[15] && interrupt_control_two_in[8];
  sequence pulse_s; pc_load_out ##1 !pc_load_out; endsequence
  pc_pulse_a: assert property (pc_load_out |-> pulse_s)
    else $error("pc load pulse too long");
  pc_value_a: assert property (pc_load_out |-> $past(handler_valid_in))
    else $error("pc load without handler");
  pc_target_a: assert property (pc_load_out |->
    program_counter_out == $past(handler_addr_in)) else $error("pc not loaded from handler");
  irq_addr_a: assert property (fetch_valid_out && !fetch_is_trap_out |->
    fetch_addr_out == base + 24'h000014 + {16'h0000, fetch_irq_out, 1'b0}) else $error("irq addr");
  trap_addr_a: assert property (fetch_valid_out && fetch_is_trap_out |->
    (fetch_addr_out - base) inside {24'h4, 24'h6, 24'h8, 24'ha, 24'hc, 24'h10}) else $error("trap");
  fetch_hold_a: assert property (fetch_valid_out && !fetch_ready_in |=>
    fetch_valid_out && $stable(fetch_addr_out)) else $error("fetch dropped early");
  alt_gate_a: assert property (1'b1 |=> alt_table_active_out == $past(en))
    else $error("alternate gate wrong");
  base_calc_a: assert property ($stable(boot_segment_limit_in) && boot_segment_limit_in != 0 |=>
    alt_table_base_out == {$past(boot_segment_limit_in) - 13'h1, 11'h000}) else $error("base");
  take_cause_a: assert property ($rose(fetch_valid_out) |->
    $past(trap_req_in || |irq_pending_in)) else $error("fetch without request");
endmodule
bind interrupt_vector_table_select vector_select_sva #(.NUM_IRQ(NUM_IRQ)) chk (
  .clk_in, .reset_n_in, .interrupt_control_two_in, .security_config_word_in,
  .boot_segment_defined_in, .boot_segment_limit_in, .trap_req_in, .irq_pending_in,
  .fetch_ready_in, .handler_addr_in, .handler_valid_in, .fetch_valid_out, .fetch_addr_out,
  .fetch_irq_out, .fetch_is_trap_out, .alt_table_active_out, .alt_table_base_out, .pc_load_out,
  .program_counter_out);

// *** dv/core_fetch_model.sv ***
/* Core side: accepts a vector fetch, returns a handler address.
   Assumes it is clocked with the block and drives at falling edges. */
`timescale 1ns/1ps
module core_fetch_model (
  input wire logic        clk_in,
  input wire logic        valid_in,
  input wire logic [23:0] pick_in,
  input wire logic [31:0] wait_in,
  output logic            ready_out = 1'b0,
  output logic            hvalid_out = 1'b0,
  output logic [23:0]     haddr_out = 24'h000000
);
  // Stalls wait_in cycles before each step; bus shows junk when idle
  always begin
    @(negedge clk_in);
    if (valid_in) begin
      repeat (wait_in) @(negedge clk_in);
      ready_out = 1'b1;
      @(negedge clk_in);
      ready_out = 1'b0;
      repeat (wait_in) @(negedge clk_in);
      hvalid_out = 1'b1;
      haddr_out = pick_in;
      @(negedge clk_in);
      hvalid_out = 1'b0;
      haddr_out = ~pick_in;
    end
  end
endmodule

// *** dv/test_interrupt_vector_table_select.sv ***
/* Random bench for the vector select block with a reference model.
   Assumes the core model answers each fetch. */
`timescale 1ns/1ps
module test_interrupt_vector_table_select;
  logic clk_in = 1'b0, reset_n_in = 1'b0, boot_segment_defined_in = 1'b0, trap_req_in = 1'b0;
  logic [15:0] interrupt_control_two_in = 16'h0000, security_config_word_in = 16'h0000;
  logic [12:0] boot_segment_limit_in = 13'h0000;
  logic [2:0] trap_num_in = 3'h0;
  logic [117:0] irq_pending_in = '0;
  logic fetch_ready_in, handler_valid_in, fetch_valid_out, fetch_is_trap_out;
  logic alt_table_active_out, pc_load_out, tk, en;
  logic [23:0] handler_addr_in, fetch_addr_out, alt_table_base_out, program_counter_out;
  logic [23:0] hnd = 24'h000000, base, want;
  logic [6:0] fetch_irq_out;
  int wt = 0, idx, t, n_fail = 0, num_checks = 0;
  int q[$];
  // Request numbers 5, 6, 21 and 23 are reserved in this build
  localparam logic [117:0] IMPL = ~118'ha00060;
  always #2.5 clk_in = ~clk_in;
  interrupt_vector_table_select #(.IRQ_IMPLEMENTED(IMPL)) uut (
    .clk_in, .reset_n_in, .interrupt_control_two_in, .security_config_word_in,
    .boot_segment_defined_in, .boot_segment_limit_in, .trap_req_in, .trap_num_in,
    .irq_pending_in, .fetch_ready_in, .handler_addr_in, .handler_valid_in,
    .fetch_valid_out, .fetch_addr_out, .fetch_irq_out, .fetch_is_trap_out,
    .alt_table_active_out, .alt_table_base_out, .pc_load_out, .program_counter_out);
  core_fetch_model core (.clk_in, .valid_in(fetch_valid_out), .pick_in(hnd), .wait_in(wt),
    .ready_out(fetch_ready_in), .hvalid_out(handler_valid_in), .haddr_out(handler_addr_in));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hang guard, well above the longest expected run
  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end
  initial begin
    void'($urandom(15));
    repeat (16) @(posedge clk_in);
    @(negedge clk_in) reset_n_in = 1'b1;
    check(program_counter_out, 24'h000000);
    repeat (80) begin
      @(negedge clk_in);
      interrupt_control_two_in = 16'($urandom);
      security_config_word_in = 16'($urandom);
      boot_segment_defined_in = 1'($urandom);
      boot_segment_limit_in = ($urandom % 4 == 0) ? 13'h0000 : 13'($urandom);
      trap_req_in = 1'($urandom);
      trap_num_in = 3'($urandom);
      repeat ($urandom % 3) irq_pending_in[$urandom % 118] = 1'b1;
      if ($urandom % 4 == 0) irq_pending_in[5] = 1'b1;
      hnd = 24'($urandom);
      wt = $urandom % 3;
      // Reference: gates, base, trap over lowest irq
      en = boot_segment_defined_in && boot_segment_limit_in != 0 &&
           security_config_word_in[15] && interrupt_control_two_in[8];
      base = en ? {boot_segment_limit_in - 13'h1, 11'h000} : 24'h000000;
      q = {};
      for (int i = 0; i < 118; i++) begin
        if (irq_pending_in[i] && IMPL[i]) q.push_back(i);
      end
      q.sort();
      idx = (q.size() > 0) ? q[0] : 118;
      tk = trap_req_in && trap_num_in != 3'h5 && trap_num_in != 3'h7;
      want = base + (tk ? 24'(4 + 2 * trap_num_in) : 24'(20 + 2 * idx));
      @(negedge clk_in);
      check(24'(alt_table_active_out), 24'(en));
      if (en) check(alt_table_base_out, base);
      for (t = 0; t < 40 && pc_load_out !== 1'b1 && (tk || idx < 118); t++) begin
        if (fetch_valid_out === 1'b1) check(fetch_addr_out, want);
        if (fetch_valid_out === 1'b1) check(24'(fetch_is_trap_out), 24'(tk));
        if (fetch_valid_out === 1'b1) check(24'(fetch_irq_out), tk ? 24'h0 : 24'(idx));
        @(negedge clk_in);
      end
      if (tk || idx < 118) begin
        check(program_counter_out, hnd);
        check(24'(pc_load_out), 24'h000001);
      end else begin
        check(24'(fetch_valid_out), 24'h000000);
      end
      trap_req_in = 1'b0;
      irq_pending_in = '0;
    end
    // Second reset after the random run: program counter and fetch return to rest
    @(negedge clk_in) reset_n_in = 1'b0;
    @(negedge clk_in);
    check(program_counter_out, 24'h000000);
    reset_n_in = 1'b1;
    repeat (2) @(negedge clk_in);
    check(program_counter_out, 24'h000000);
    check(24'(fetch_valid_out), 24'h000000);
    end_of_test();
  end
endmodule
